//--- inc/flmc_consts.vh
// Constants for the flash LED mode and fault control core.
// Assumes a 100 MHz core clock and a serial slave outside that decodes accesses.
//
// Operation
// - Filtered open-LED overvoltage in torch/flash sets flag, attention, forces ready.
// - Thermistor warning level sets flag and attention, mode unchanged.
// - Thermistor hot level sets flag, attention, forces ready.
// - Die overheat trip forces ready, sets flag and attention.
// - Overcurrent flag follows limit live, no latch, attention or mode change.
// - Output short flag high during 360 us precharge; stays high if no 100 mV.
// - Latched flags set by events, cleared only by a status read.
// - Flash running and overcurrent flags are live; all flags reset to zero.
// - After power-on, hold reset about 1 us, release attention, sample strap.
// - Shutdown keeps only serial side alive; entered on reset or power-up bit clear.
// - Ready: blocks on, converter off, LED off, indicator allowed only here.
// - Ready entered from shutdown, from flash drop or time-out, from torch clear.
// - Hard-triggered flash lasts as long as strobe, capped by time-out.
// - Time-out counter accumulates across pulses; command write reloads it.
// - Time-out clears arm bit and running flag, returns ready, pulls attention.
// - Internally timed flash end pulls attention low for 11 us.
// - Time-out field 0..15 means 0..1.5 s in 100 ms steps, field unchanged.
// - Flash active is arm bit AND strobe, and only with power-up bit set.
// - Flash running flag is high for the whole of flash mode.
// - Status bits MSB..LSB: short, running, open, warn, hot, overheat, overcurrent, short-out.
`ifndef FLMC_CONSTS_VH
`define FLMC_CONSTS_VH

`define FLMC_CLK_MHZ 100
`define FLMC_POR_TIME_NS 1000
`define FLMC_POR_CYCLES ((`FLMC_POR_TIME_NS * `FLMC_CLK_MHZ) / 1000)
`define FLMC_PRECHARGE_TIME_US 360
`define FLMC_PRECHARGE_CYCLES (`FLMC_PRECHARGE_TIME_US * `FLMC_CLK_MHZ)
`define FLMC_TICK_TIME_MS 100
`define FLMC_TICK_CYCLES (`FLMC_TICK_TIME_MS * 1000 * `FLMC_CLK_MHZ)
`define FLMC_ATN_PULSE_TIME_US 11
`define FLMC_ATN_PULSE_CYCLES (`FLMC_ATN_PULSE_TIME_US * `FLMC_CLK_MHZ)
`define FLMC_FILTER_CYCLES 4

`define FLMC_CMD_RESET 8'h00
`define FLMC_STAT_RESET 8'h00
`define FLMC_CMD_POWER_UP_BIT 7
`define FLMC_CMD_ARM_BIT 6
`define FLMC_CMD_TORCH_BIT 5
`define FLMC_CMD_THERM_BIT 4
`define FLMC_CMD_TIMEOUT_MSB 3
`define FLMC_CMD_TIMEOUT_LSB 0

`define FLMC_ST_SHORT_LED 7
`define FLMC_ST_FLASH_RUN 6
`define FLMC_ST_OPEN_LED 5
`define FLMC_ST_THERM_WARN 4
`define FLMC_ST_THERM_HOT 3
`define FLMC_ST_DIE_HOT 2
`define FLMC_ST_OVERCURRENT 1
`define FLMC_ST_OUT_SHORT 0

`endif

//--- hw/flmc_filter.v
// Spike filter: output follows input only after it holds steady N cycles.
// Assumes the input is already synchronised to CLK.
`timescale 1ns/1ps
`default_nettype none
module flmc_filter #(
    parameter integer N = 4
) (
    input wire clk,
    input wire rst,
    input wire din,
    output reg dout
);
    reg [7:0] cnt_reg;

    always @(posedge clk) begin
        if (rst) begin
            cnt_reg <= 8'h00;
            dout <= 1'b0;
        end else if (din == dout) begin
            cnt_reg <= 8'h00;
        end else if (cnt_reg == N[7:0] - 8'h01) begin
            cnt_reg <= 8'h00;
            dout <= din;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- hw/flmc_core.v
// Mode sequencer, fault flags and flash time-out for the flash LED driver.
// Assumes a serial slave drives CMD_WR/CMD_WDATA and STAT_RD; analog inputs are async comparators.
`timescale 1ns/1ps
`default_nettype none
`include "flmc_consts.vh"
module flmc_core #(
    parameter integer POR_CYCLES = `FLMC_POR_CYCLES,
    parameter integer PRECHARGE_CYCLES = `FLMC_PRECHARGE_CYCLES,
    parameter integer TICK_CYCLES = `FLMC_TICK_CYCLES,
    parameter integer ATN_PULSE_CYCLES = `FLMC_ATN_PULSE_CYCLES
) (
    input wire CLK,
    input wire RST,
    input wire CMD_WR,
    input wire [7:0] CMD_WDATA,
    input wire STAT_RD,
    input wire FLASH_STROBE_PIN,
    input wire ADDR_STRAP,
    input wire OPEN_LED_CMP,
    input wire SHORT_LED_CMP,
    input wire THERM_WARN_CMP,
    input wire THERM_HOT_CMP,
    input wire DIE_HOT_CMP,
    input wire OVERCURRENT_CMP,
    input wire OUT_OK_CMP,
    output reg [7:0] CMD_RDATA,
    output reg [7:0] STATUS_FLAGS,
    output reg [1:0] MODE,
    output reg ATTENTION_N_O,
    output reg ATTENTION_N_OE_N,
    output reg SDA_RELEASE,
    output reg ADDR_SEL,
    output reg CONVERTER_EN,
    output reg LED_CONNECT,
    output reg PRECHARGE_EN,
    output reg THERM_BIAS_EN,
    output reg INDICATOR_EN,
    output reg FLASH_SEL
);
    localparam [1:0] M_SHUTDOWN = 2'b00;
    localparam [1:0] M_READY = 2'b01;
    localparam [1:0] M_TORCH = 2'b10;
    localparam [1:0] M_FLASH = 2'b11;
    localparam integer NSYNC = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers, one per async input
    wire [NSYNC-1:0] async_in;
    reg [NSYNC-1:0] sync1_reg;
    reg [NSYNC-1:0] sync2_reg;
    assign async_in = {FLASH_STROBE_PIN, OPEN_LED_CMP, SHORT_LED_CMP, THERM_WARN_CMP,
                       THERM_HOT_CMP, DIE_HOT_CMP, OVERCURRENT_CMP, OUT_OK_CMP};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge CLK) begin
                if (RST) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= async_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate
    wire strobe_s = sync2_reg[7];
    wire short_s = sync2_reg[5];
    wire warn_s = sync2_reg[4];
    wire hot_s = sync2_reg[3];
    wire die_s = sync2_reg[2];
    wire oc_s = sync2_reg[1];
    wire outok_s = sync2_reg[0];
    reg strap_s1_reg;
    reg strap_s2_reg;

    // Open-LED comparator sees switching spikes, so it is filtered
    wire open_f;
    flmc_filter #(.N(`FLMC_FILTER_CYCLES)) u_open_filter (
        .clk(CLK),
        .rst(RST),
        .din(sync2_reg[6]),
        .dout(open_f)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Power-on hold
    reg [7:0] por_cnt_reg;
    wire por_busy = (por_cnt_reg != 8'h00);

    always @(posedge CLK) begin
        if (RST) begin
            por_cnt_reg <= POR_CYCLES[7:0];
            strap_s1_reg <= 1'b0;
            strap_s2_reg <= 1'b0;
            ADDR_SEL <= 1'b0;
        end else begin
            strap_s1_reg <= ADDR_STRAP;
            strap_s2_reg <= strap_s1_reg;
            if (por_busy) begin
                por_cnt_reg <= por_cnt_reg - 8'h01;
                ADDR_SEL <= strap_s2_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command register and mode sequencer
    reg [7:0] cmd_reg;
    reg [1:0] mode_reg;
    reg [1:0] mode_next;
    reg [3:0] tout_cnt_reg;
    reg [31:0] tick_cnt_reg;
    reg [15:0] pulse_cnt_reg;
    reg [15:0] pre_cnt_reg;
    reg pre_done_reg;
    reg [7:0] latched_reg;

    wire wr_ok = CMD_WR && !por_busy;
    wire power_up = cmd_reg[`FLMC_CMD_POWER_UP_BIT];
    wire arm = cmd_reg[`FLMC_CMD_ARM_BIT];
    wire torch = cmd_reg[`FLMC_CMD_TORCH_BIT];
    wire flash_active = arm && strobe_s && power_up;
    wire lit = (mode_reg == M_TORCH) || (mode_reg == M_FLASH);
    wire open_ev = lit && open_f;
    wire short_ev = lit && short_s;
    wire hot_ev = hot_s;
    wire warn_ev = warn_s;
    wire die_ev = die_s;
    wire outshort_ev = pre_done_reg && !outok_s && power_up;
    // Faults that force ready
    // Latched open, hot, overheat and output-short faults hold ready until read, else torch would retry straight into the fault
    wire force_ready = open_ev || hot_ev || die_ev || latched_reg[`FLMC_ST_OPEN_LED] ||
                       latched_reg[`FLMC_ST_THERM_HOT] || latched_reg[`FLMC_ST_DIE_HOT] ||
                       latched_reg[`FLMC_ST_OUT_SHORT];
    wire tick = (tick_cnt_reg == TICK_CYCLES - 1);
    wire timeout = (mode_reg == M_FLASH) && flash_active && tick && (tout_cnt_reg <= 4'h1);
    wire zero_tout = (mode_reg == M_FLASH) && (tout_cnt_reg == 4'h0);
    wire flash_end = timeout || zero_tout;

    always @* begin
        mode_next = mode_reg;
        case (mode_reg)
            M_SHUTDOWN: begin
                if (power_up && !por_busy && pre_done_reg && outok_s)
                    mode_next = M_READY;
            end
            M_READY: begin
                if (!power_up)
                    mode_next = M_SHUTDOWN;
                else if (force_ready)
                    mode_next = M_READY;
                else if (flash_active && tout_cnt_reg != 4'h0)
                    mode_next = M_FLASH;
                else if (torch)
                    mode_next = M_TORCH;
            end
            M_TORCH: begin
                if (!power_up)
                    mode_next = M_SHUTDOWN;
                else if (force_ready || !torch)
                    mode_next = M_READY;
                else if (flash_active && tout_cnt_reg != 4'h0)
                    mode_next = M_FLASH;
            end
            M_FLASH: begin
                if (!power_up)
                    mode_next = M_SHUTDOWN;
                else if (force_ready || !flash_active || flash_end)
                    mode_next = M_READY;
            end
            default: mode_next = M_SHUTDOWN;
        endcase
    end

    always @(posedge CLK) begin
        if (RST) begin
            cmd_reg <= `FLMC_CMD_RESET;
            mode_reg <= M_SHUTDOWN;
            tout_cnt_reg <= 4'h0;
            tick_cnt_reg <= 32'h0000_0000;
        end else begin
            mode_reg <= mode_next;
            if (wr_ok) begin
                cmd_reg <= CMD_WDATA;
                tout_cnt_reg <= CMD_WDATA[`FLMC_CMD_TIMEOUT_MSB:`FLMC_CMD_TIMEOUT_LSB];
                tick_cnt_reg <= 32'h0000_0000;
            end else begin
                if (flash_end)
                    cmd_reg[`FLMC_CMD_ARM_BIT] <= 1'b0;
                // Counter only runs in flash mode with the flash active, so gaps between pulses add nothing
                if (mode_reg == M_FLASH && flash_active) begin
                    if (tick) begin
                        tick_cnt_reg <= 32'h0000_0000;
                        if (tout_cnt_reg != 4'h0)
                            tout_cnt_reg <= tout_cnt_reg - 4'h1;
                    end else begin
                        tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output precharge check at start-up
    always @(posedge CLK) begin
        if (RST) begin
            pre_cnt_reg <= 16'h0000;
            pre_done_reg <= 1'b0;
        end else if (!power_up || por_busy) begin
            pre_cnt_reg <= 16'h0000;
            pre_done_reg <= 1'b0;
        end else if (!pre_done_reg) begin
            if (pre_cnt_reg == PRECHARGE_CYCLES[15:0] - 16'h0001)
                pre_done_reg <= 1'b1;
            else
                pre_cnt_reg <= pre_cnt_reg + 16'h0001;
        end
    end
    wire precharging = power_up && !por_busy && !pre_done_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Status flags: set beats the read clear
    wire [7:0] set_vec;
    assign set_vec = {short_ev, 1'b0, open_ev, warn_ev, hot_ev, die_ev, 1'b0, outshort_ev};
    wire rd_ok = STAT_RD && !por_busy;

    always @(posedge CLK) begin
        if (RST) begin
            latched_reg <= `FLMC_STAT_RESET;
        end else begin
            latched_reg <= (rd_ok ? 8'h00 : latched_reg) | set_vec;
        end
    end

    wire [7:0] status_next;
    assign status_next = {latched_reg[7], (mode_next == M_FLASH), latched_reg[5:2], oc_s,
                          latched_reg[0] | precharging};

    ////////////////////////////////////////////////////////////////////////////
    // Attention line: level from latched faults, plus a pulse when a timed flash ends
    always @(posedge CLK) begin
        if (RST) begin
            pulse_cnt_reg <= 16'h0000;
        end else if (flash_end && mode_reg == M_FLASH) begin
            pulse_cnt_reg <= ATN_PULSE_CYCLES[15:0];
        end else if (pulse_cnt_reg != 16'h0000) begin
            pulse_cnt_reg <= pulse_cnt_reg - 16'h0001;
        end
    end
    // Overcurrent bit excluded: it never asks for attention
    wire atn_assert = (latched_reg != 8'h00) || (pulse_cnt_reg != 16'h0000);

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always @(posedge CLK) begin
        if (RST) begin
            CMD_RDATA <= `FLMC_CMD_RESET;
            STATUS_FLAGS <= `FLMC_STAT_RESET;
            MODE <= M_SHUTDOWN;
            ATTENTION_N_O <= 1'b0;
            ATTENTION_N_OE_N <= 1'b1;
            SDA_RELEASE <= 1'b1;
            CONVERTER_EN <= 1'b0;
            LED_CONNECT <= 1'b0;
            PRECHARGE_EN <= 1'b0;
            THERM_BIAS_EN <= 1'b0;
            INDICATOR_EN <= 1'b0;
            FLASH_SEL <= 1'b0;
        end else begin
            CMD_RDATA <= cmd_reg;
            STATUS_FLAGS <= status_next;
            MODE <= mode_reg;
            ATTENTION_N_O <= 1'b0;
            ATTENTION_N_OE_N <= por_busy ? 1'b1 : !atn_assert;
            SDA_RELEASE <= por_busy;
            CONVERTER_EN <= (mode_reg == M_TORCH) || (mode_reg == M_FLASH);
            LED_CONNECT <= (mode_reg == M_TORCH) || (mode_reg == M_FLASH);
            PRECHARGE_EN <= precharging;
            THERM_BIAS_EN <= (mode_reg != M_SHUTDOWN) && (cmd_reg[`FLMC_CMD_THERM_BIT] || mode_reg != M_READY);
            INDICATOR_EN <= (mode_reg == M_READY);
            FLASH_SEL <= (mode_reg == M_FLASH);
        end
    end
endmodule
`default_nettype wire

//--- dv/flmc_core_asserts.sv
// Checker for the flash LED mode and fault core, bound to its ports.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module flmc_core_asserts (
    input wire logic CLK,
    input wire logic RST,
    input wire logic STAT_RD,
    input wire logic THERM_HOT_CMP,
    input wire logic DIE_HOT_CMP,
    input wire logic OVERCURRENT_CMP,
    input wire logic [7:0] STATUS_FLAGS,
    input wire logic [1:0] MODE,
    input wire logic ATTENTION_N_OE_N,
    input wire logic SDA_RELEASE,
    input wire logic CONVERTER_EN,
    input wire logic LED_CONNECT
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    ////////////////////////////////////////
    a_flags_reset: assert property ($fell(RST) |-> STATUS_FLAGS == 8'h00)
        else $error("status not clear after reset");
    a_hold_release: assert property ($fell(RST) |-> ATTENTION_N_OE_N && SDA_RELEASE)
        else $error("pins not released in power-on hold");
    a_overcur_live: assert property (OVERCURRENT_CMP [*6] |-> STATUS_FLAGS[1])
        else $error("overcurrent flag missing");
    a_overcur_gone: assert property (!OVERCURRENT_CMP [*6] |-> !STATUS_FLAGS[1])
        else $error("overcurrent flag latched");
    // Bits 6, 1 and 0 excluded: 6 and 1 are live, and 0 also clears when precharge succeeds
    a_latch_hold: assert property (!STAT_RD && !$past(STAT_RD) |=> ($past(STATUS_FLAGS) & ~STATUS_FLAGS & 8'hBC) == 8'h00)
        else $error("latched flag cleared without read");
    // Flag follows the internal mode, MODE lags it by one edge
    a_run_flag: assert property ((MODE == 2'd3) == $past(STATUS_FLAGS[6]))
        else $error("running flag low in flash");
    a_ready_dark: assert property ((MODE == 2'd1) [*3] |-> !CONVERTER_EN && !LED_CONNECT)
        else $error("converter or LED on in ready");
    a_shutdown_dark: assert property ((MODE == 2'd0) [*3] |-> !CONVERTER_EN && !LED_CONNECT)
        else $error("converter or LED on in shutdown");
    a_hot_ready: assert property (THERM_HOT_CMP [*8] |-> MODE == 2'd0 || MODE == 2'd1)
        else $error("hot LED did not force ready");
    a_die_ready: assert property (DIE_HOT_CMP [*8] |-> MODE == 2'd0 || MODE == 2'd1)
        else $error("die overheat did not force ready");
    a_warn_attn: assert property ($rose(STATUS_FLAGS[4]) |-> ##[0:2] !ATTENTION_N_OE_N)
        else $error("warning without attention");
endmodule
bind flmc_core flmc_core_asserts u_chk (.CLK(CLK), .RST(RST), .STAT_RD(STAT_RD), .THERM_HOT_CMP(THERM_HOT_CMP),
    .DIE_HOT_CMP(DIE_HOT_CMP), .OVERCURRENT_CMP(OVERCURRENT_CMP), .STATUS_FLAGS(STATUS_FLAGS), .MODE(MODE),
    .ATTENTION_N_OE_N(ATTENTION_N_OE_N), .SDA_RELEASE(SDA_RELEASE), .CONVERTER_EN(CONVERTER_EN),
    .LED_CONNECT(LED_CONNECT));
`default_nettype wire

//--- dv/flmc_host.sv
// Host model: serial command writes, status reads and the strobe pin.
// Assumes the core clock is given; strobe moves on link clock, landed on the core clock.
`timescale 1ns/1ps
`default_nettype none
module flmc_host (
    input wire logic clk,
    output logic cmd_wr,
    output logic [7:0] cmd_wdata,
    output logic stat_rd,
    output logic strobe
);
    logic link_clk;
    initial begin
        cmd_wr = 1'b0;
        cmd_wdata = 8'h00;
        stat_rd = 1'b0;
        strobe = 1'b1;
        link_clk = 1'b0;
        forever #80 link_clk = ~link_clk;
    end
    ////////////////////////////////////////
    // Data inverted afterwards so a stale byte is never mistaken for a write
    task automatic wr(input logic [7:0] v);
        @(posedge clk);
        cmd_wr <= 1'b1;
        cmd_wdata <= v;
        @(posedge clk);
        cmd_wr <= 1'b0;
        cmd_wdata <= ~v;
    endtask
    task automatic rd();
        @(posedge clk);
        stat_rd <= 1'b1;
        @(posedge clk);
        stat_rd <= 1'b0;
    endtask
    task automatic pin(input logic v);
        @(posedge link_clk);
        @(posedge clk);
        strobe <= v;
    endtask
endmodule
`default_nettype wire

//--- dv/flmc_core_bench.sv
// Self-checking bench for the flash LED mode and fault core.
// Assumes shortened precharge, tick and pulse counts set at the instance.
`timescale 1ns/1ps
`default_nettype none
module flmc_core_bench;
    logic CLK, RST, OUT_OK, strap;
    logic [5:0] cmp;
    wire cmd_wr, stat_rd, strobe, atn_o, atn_oe_n, sda_rel, conv_en, led_con;
    wire addr_sel, pre_en, therm_en, ind_en, flash_sel;
    wire [7:0] cmd_wdata, CMD_RDATA, STATUS_FLAGS;
    wire [1:0] MODE;
    int num_errors = 0;
    int tests_run = 0;
    int n;
    // {comparator, status bit, forces ready, pulls attention, latched}
    logic [8:0] rows [6] = '{9'h02F, 9'h07B, 9'h0A3, 9'h0DF, 9'h117, 9'h148};
    flmc_host host (.clk(CLK), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .stat_rd(stat_rd), .strobe(strobe));
    flmc_core #(.POR_CYCLES(100), .PRECHARGE_CYCLES(50), .TICK_CYCLES(100), .ATN_PULSE_CYCLES(20)) uut (
        .CLK(CLK), .RST(RST), .CMD_WR(cmd_wr), .CMD_WDATA(cmd_wdata), .STAT_RD(stat_rd),
        .FLASH_STROBE_PIN(strobe), .ADDR_STRAP(strap), .OPEN_LED_CMP(cmp[0]), .SHORT_LED_CMP(cmp[1]),
        .THERM_WARN_CMP(cmp[2]), .THERM_HOT_CMP(cmp[3]), .DIE_HOT_CMP(cmp[4]), .OVERCURRENT_CMP(cmp[5]),
        .OUT_OK_CMP(OUT_OK), .CMD_RDATA(CMD_RDATA), .STATUS_FLAGS(STATUS_FLAGS), .MODE(MODE),
        .ATTENTION_N_O(atn_o), .ATTENTION_N_OE_N(atn_oe_n), .SDA_RELEASE(sda_rel), .ADDR_SEL(addr_sel),
        .CONVERTER_EN(conv_en), .LED_CONNECT(led_con), .PRECHARGE_EN(pre_en), .THERM_BIAS_EN(therm_en),
        .INDICATOR_EN(ind_en), .FLASH_SEL(flash_sel));
    ////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input bit ok, input string m);
        tests_run++;
        if (!ok) begin
            num_errors++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic wait_mode(input logic [1:0] m, input int lim);
        int i;
        i = 0;
        while (MODE !== m && i < lim) begin
            @(posedge CLK);
            i++;
        end
        chk(MODE === m, "mode wait ran out");
        if (MODE !== m) print_verdict();
    endtask
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    initial begin
        repeat (100000) @(posedge CLK);
        chk(1'b0, "run hung");
        print_verdict();
    end
    initial begin
        RST = 1'b1;
        OUT_OK = 1'b1;
        strap = 1'b1;
        cmp = 6'h00;
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        // Write lands inside the power-on hold and must vanish
        host.wr(8'h80);
        chk(sda_rel === 1'b1 && atn_oe_n === 1'b1 && STATUS_FLAGS === 8'h00 && atn_o === 1'b0, "hold state");
        repeat (110) @(posedge CLK);
        chk(CMD_RDATA === 8'h00 && MODE === 2'd0, "write taken in hold");
        chk(sda_rel === 1'b0 && addr_sel === 1'b1 && atn_o === 1'b0, "hold end");
        host.wr(8'h80);
        repeat (10) @(posedge CLK);
        chk(STATUS_FLAGS[0] === 1'b1 && pre_en === 1'b1, "short flag low in precharge");
        wait_mode(2'd1, 200);
        chk(STATUS_FLAGS[0] === 1'b0 && conv_en === 1'b0 && led_con === 1'b0, "ready outputs");
        chk(pre_en === 1'b0 && ind_en === 1'b1 && therm_en === 1'b0, "ready side outputs");
        $display("startup test done");
        foreach (rows[k]) begin
            host.rd();
            host.wr(8'h80);
            host.wr(8'hA0);
            wait_mode(2'd2, 20);
            chk(ind_en === 1'b0 && therm_en === 1'b1 && conv_en === 1'b1, "torch outputs");
            @(posedge CLK);
            cmp[rows[k][8:6]] <= 1'b1;
            repeat (10) @(posedge CLK);
            chk(STATUS_FLAGS[rows[k][5:3]] === 1'b1, "fault flag not set");
            chk((MODE === 2'd1) === rows[k][2], "mode after fault");
            chk((atn_oe_n === 1'b0) === rows[k][1], "attention after fault");
            cmp[rows[k][8:6]] <= 1'b0;
            repeat (8) @(posedge CLK);
            chk(STATUS_FLAGS[rows[k][5:3]] === rows[k][0], "flag after fault gone");
            host.rd();
            repeat (4) @(posedge CLK);
            chk(STATUS_FLAGS[rows[k][5:3]] === 1'b0, "flag after read");
            $display("fault row %0d done", k);
        end
        // Soft trigger: write restarts the tick, so exactly three ticks of flash
        host.wr(8'h90);
        repeat (3) @(posedge CLK);
        chk(therm_en === 1'b1 && ind_en === 1'b1 && conv_en === 1'b0, "monitor in ready");
        host.wr(8'hC3);
        wait_mode(2'd3, 10);
        chk(flash_sel === 1'b1 && STATUS_FLAGS[6] === 1'b1 && atn_oe_n === 1'b1, "flash outputs");
        n = 0;
        while (MODE === 2'd3 && n < 800) begin
            @(posedge CLK);
            n++;
        end
        chk(n >= 299 && n <= 301, "soft flash length");
        // Pulse starts with the mode change, so it is timed from here
        n = 0;
        while (atn_oe_n !== 1'b0 && n < 50) begin
            @(posedge CLK);
            n++;
        end
        n = 0;
        while (atn_oe_n === 1'b0 && n < 100) begin
            @(posedge CLK);
            n++;
        end
        chk(n >= 19 && n <= 21, "end-of-flash attention pulse");
        repeat (3) @(posedge CLK);
        chk(MODE === 2'd1 && CMD_RDATA === 8'h83 && STATUS_FLAGS[6] === 1'b0, "after time-out");
        $display("soft flash test done");
        // Hard trigger: 3 x 150 cycles of a 500-cycle budget, then a long pulse
        host.pin(1'b0);
        host.wr(8'hC5);
        repeat (10) @(posedge CLK);
        chk(MODE === 2'd1, "flash without strobe");
        repeat (3) begin
            host.pin(1'b1);
            wait_mode(2'd3, 10);
            repeat (150) @(posedge CLK);
            host.pin(1'b0);
            wait_mode(2'd1, 10);
        end
        host.pin(1'b1);
        wait_mode(2'd3, 10);
        n = 0;
        while (MODE === 2'd3 && n < 800) begin
            @(posedge CLK);
            n++;
        end
        repeat (3) @(posedge CLK);
        chk(n <= 200 && CMD_RDATA[6] === 1'b0 && MODE === 2'd1, "time-out did not accumulate");
        // Rewriting the command mid-flash reloads the count and stretches the flash
        host.wr(8'hC2);
        wait_mode(2'd3, 10);
        repeat (150) @(posedge CLK);
        host.wr(8'hC2);
        n = 0;
        while (MODE === 2'd3 && n < 800) begin
            @(posedge CLK);
            n++;
        end
        chk(n >= 195 && n <= 210, "reload did not extend flash");
        host.wr(8'h00);
        wait_mode(2'd0, 10);
        $display("hard flash test done");
        // Second reset with the output held shorted
        @(posedge CLK);
        RST <= 1'b1;
        OUT_OK <= 1'b0;
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        repeat (105) @(posedge CLK);
        strap <= 1'b0;
        host.wr(8'hA0);
        repeat (120) @(posedge CLK);
        chk(STATUS_FLAGS[0] === 1'b1 && atn_oe_n === 1'b0 && MODE !== 2'd2, "shorted start");
        chk(addr_sel === 1'b1, "strap sampled after hold");
        $display("short output test done");
        print_verdict();
    end
endmodule
`default_nettype wire
